// >>> tb/tc_panel_model.sv
// Purpose: panel side model, counts strobe activity over a window
// Assumes: panel samples on every system clock edge
// Notes:   six-bit panel wiring keeps bits 7 to 2 of each colour
module tc_panel_model
  import tc_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             start,
  input  wire logic [15:0]      len,
  input  wire logic [9:0]       sig,
  input  wire logic [23:0]      rgb,
  input  wire logic             de,
  output logic                  done,
  output logic      [9:0][15:0] hi,
  output logic      [9:0][15:0] ri,
  output logic      [17:0]      cap,
  output logic      [23:0]      full
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] left = '0;  // clocks still to count
  logic [9:0]  prev;       // last sample, for edges
  // count highs and rising edges while the window is open
  always @(posedge clock) begin
    prev <= sig;
    done <= !start && left == 16'h0001;
    if (start) begin
      left <= len;
      hi   <= '0;
      ri   <= '0;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
      for (int i = 0; i < 10; i++) begin
        hi[i] <= hi[i] + 16'(sig[i]);
        ri[i] <= ri[i] + 16'(sig[i] & !prev[i]);
      end
    end
    // six-bit panel takes the top bits only
    if (de) begin
      cap  <= {rgb[23:18], rgb[15:10], rgb[7:2]};
      full <= rgb;  // eight-bit panel takes all bits
    end
  end
endmodule

// >>> tb/tc_timing_ctrl_props.sv
// Purpose: port checks of the panel timing controller
// Assumes: bound to tc_timing_ctrl, one clock domain
// Notes:   read checks fire at the edge that completes a read
module tc_timing_ctrl_props
  import tc_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [23:0] rgb_out,
  input wire logic        data_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // request seen while the slave still waits
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // read completing at this edge
  sequence s_rd;
    avs_read && !avs_waitrequest;
  endsequence
  a_wait_once: assert property (s_take |=> !avs_waitrequest ##1
    avs_waitrequest) else $error("slave wait not exactly one cycle");
  a_no_answer: assert property (!avs_read && !avs_write &&
    avs_waitrequest |=> avs_waitrequest) else $error("answer without request");
  a_miss_zero: assert property (s_rd ##0 (avs_address[1:0] != 2'h0 ||
    avs_address >= 8'ha0 || avs_address == 8'h64) |-> avs_readdata == '0)
    else $error("unmapped read not zero");
  a_pos_width: assert property (s_rd ##0 (avs_address >= TC_POS_OFS) |->
    avs_readdata[31:12] == 20'h0_0000) else $error("position wider than 12");
  a_stat_fields: assert property (s_rd ##0 avs_address == TC_STAT_OFS |->
    avs_readdata[31:28] == 4'h0 && avs_readdata[15:12] == 4'h0)
    else $error("status spare bits set");
  a_ctrl_fields: assert property (s_rd ##0 avs_address == TC_CTRL_OFS |->
    avs_readdata[31:21] == 11'h000 && avs_readdata[11:4] == 8'h00)
    else $error("control spare bits set");
  a_type_fields: assert property (s_rd ##0 avs_address == TC_TYPE_OFS |->
    avs_readdata[31:6] == '0) else $error("type spare bits set");
  a_ss_clamp: assert property (s_rd ##0 avs_address == TC_CLK_OFS |->
    avs_readdata[19:16] <= TC_SS_MAX) else $error("spread level above five");
  a_rgb_blank: assert property (!data_enable |-> rgb_out == 24'h00_0000)
    else $error("pixel data outside image");
endmodule

bind tc_timing_ctrl tc_timing_ctrl_props tc_timing_ctrl_props_i (
  .clock(clock), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rgb_out(rgb_out),
  .data_enable(data_enable));

// >>> tb/tc_timing_ctrl_tb.sv
// Purpose: self-checking bench for the panel timing controller
// Assumes: small 60 x 26 frame, pixel period 1 then 2 clocks
// Notes:   counts over one whole frame do not depend on phase
module tc_timing_ctrl_tb
  import tc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int H = 60;  // line length
  localparam int V = 26;  // frame length
  localparam int PT [6][4] = '{'{2, 5, 1, 3}, '{10, 4, 2, 4},
    '{30, 0, 0, 25}, '{50, 58, 5, 6}, '{55, 3, 7, 8}, '{20, 20, 0, 25}};
  logic clock = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, d;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [23:0] pixel_in = '0, rgb_out, px;
  logic        avs_waitrequest, data_enable, start = 1'b0, done;
  logic [9:0]  sig;
  logic [15:0] len = '0;
  logic [9:0][15:0] hi, ri;
  logic [17:0] cap;
  logic [23:0] full;
  logic [31:0] q [$];       // expected results, oldest first
  int error_cnt = 0, checked = 0, seed = 35940;
  tc_timing_ctrl tc_timing_ctrl_i (.clock(clock), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pixel_in(pixel_in), .rgb_out(rgb_out), .data_enable(data_enable),
    .source_start_strobe(sig[0]), .source_output_enable(sig[1]),
    .com_toggle_strobe(sig[2]), .gate_shift_clock(sig[3]),
    .gate_start_strobe(sig[4]), .gate_output_enable(sig[5]),
    .pixel_clock_out_a(sig[7]), .pixel_clock_out_b(sig[8]),
    .pixel_clock_out_c(sig[9]));
  assign sig[6] = data_enable;
  tc_panel_model tc_panel_model_i (.clock(clock), .start(start), .len(len),
    .sig(sig), .rgb(rgb_out), .de(data_enable), .done(done), .hi(hi),
    .ri(ri), .cap(cap), .full(full));
  always #5 clock = ~clock;
  // print counts and verdict, then stop
  task automatic finish_test;
    if (q.size() != 0) error_cnt++;  // notes never answered
    $display("counts: checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // compare one result with the oldest note
  task automatic cmp(logic [31:0] got);
    logic [31:0] e;
    e = q.pop_front();
    checked++;
    if (got !== e) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, e);
    end
  endtask
  // one avalon cycle, held until waitrequest is seen low
  task automatic bus(logic [7:0] a, logic [31:0] wd, bit w);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    if (w) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] wd);
    bus(a, wd, 1'b1);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    q.push_back(e);
    bus(a, '0, 1'b0);
  endtask
  // note highs and rises of one window over a frame
  task automatic note(int hs, he, vs, ve, bit fr, int m, bit on);
    int n;
    n = fr ? (ve * H + he) - (vs * H + hs) + 1
           : (he < hs ? 0 : (he - hs + 1) * (ve - vs + 1));
    if (!on) n = 0;
    q.push_back(32'(n * m));
    q.push_back(n == 0 ? '0 : (fr ? 32'h1 : 32'(ve - vs + 1)));
  endtask
  // settle one frame, then count one frame in the panel model
  task automatic measure(logic [31:0] c, logic [5:0] ft, int m);
    int n;
    for (int i = 0; i < 6; i++) begin
      if (i == TC_STB_CT && !ft[i] && c[TC_PIN_OF[i]]) begin
        // com row flips on all 26 lines: high half a frame
        q.push_back(32'(H * V * m / 2));
        q.push_back(32'(V / 2));
      end else begin
        note(PT[i][0], PT[i][1], PT[i][2], PT[i][3], ft[i], m,
             c[TC_PIN_OF[i]]);
      end
    end
    note(48, 55, 22, 24, 1'b0, m, 1'b1);
    q.push_back(c[TC_PIN_CKA] ? 32'(H * V) : '0);
    q.push_back(c[TC_PIN_CKA] ? 32'(H * V) : '0);
    q.push_back('0);
    q.push_back('0);
    // clock c is only selected at period two, where it toggles
    q.push_back(c[TC_PIN_CKC] ? 32'(H * V) : '0);
    q.push_back(c[TC_PIN_CKC] ? 32'(H * V) : '0);
    q.push_back({14'h0000, px[23:18], px[15:10], px[7:2]});
    q.push_back({8'h00, px});
    repeat (H * V * m) @(posedge clock);
    start <= 1'b1;
    len <= 16'(H * V * m);
    @(posedge clock);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    if (done !== 1'b1) error_cnt++;  // model window never closed
    $display("test done: frame window, period %0d", m);
  endtask
  // results are taken off the queue as they appear
  always @(posedge clock) begin
    if (avs_read && avs_waitrequest === 1'b0) cmp(avs_readdata);
    if (done === 1'b1) begin
      for (int i = 0; i < 10; i++) begin
        cmp({16'h0000, hi[i]});
        cmp({16'h0000, ri[i]});
      end
      cmp({14'h0000, cap});
      cmp({8'h00, full});
    end
  end
  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    rd(TC_CTRL_OFS, '0);
    rd(TC_TYPE_OFS, 32'(TC_TYPE_RST));
    rd(TC_HTOT_OFS, 32'(TC_HTOT_RST));
    rd(TC_VTOT_OFS, 32'(TC_VTOT_RST));
    wr(TC_STAT_OFS, 32'hffff_ffff);
    rd(TC_STAT_OFS, '0);
    rd(8'h01, '0);
    rd(8'ha0, '0);
    wr(TC_POS_OFS, 32'hffff_ffff);
    rd(TC_POS_OFS, 32'h0000_0fff);
    d = $random(seed);
    wr(TC_PLL_OFS, d);
    rd(TC_PLL_OFS, d & 32'h0003_ffff);
    wr(TC_CLK_OFS, 32'h0009_0001);
    rd(TC_CLK_OFS, 32'h0005_0001);
    wr(TC_CLK_OFS, 32'h0003_0001);
    rd(TC_CLK_OFS, 32'h0003_0001);
    $display("test done: registers");
    wr(TC_HTOT_OFS, 32'(H));
    wr(TC_VTOT_OFS, 32'(V));
    wr(TC_HACT_OFS, 32'h0000_0008);
    wr(TC_VACT_OFS, 32'h0000_0003);
    for (int s = 0; s < 6; s++)
      for (int k = 0; k < 4; k++)
        wr(TC_POS_OFS + 8'(4 * (s * 4 + k)), 32'(PT[s][k]));
    wr(TC_DIV_OFS, '0);
    px = 24'($random(seed));
    pixel_in <= px;
    wr(TC_TYPE_OFS, 32'h0000_0012);
    wr(TC_CTRL_OFS, 32'h001f_8001);
    measure(32'h001f_8001, 6'h12, 1);
    wr(TC_TYPE_OFS, 32'h0000_002d);
    wr(TC_DIV_OFS, 32'h0000_0010);
    wr(TC_CTRL_OFS, 32'h000f_d009);
    measure(32'h000f_d009, 6'h2d, 2);
    // reset again mid-run: registers back to defaults
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    rd(TC_CTRL_OFS, '0);
    rd(TC_HTOT_OFS, 32'(TC_HTOT_RST));
    rd(TC_STAT_OFS, '0);
    $display("test done: reset mid-run");
    @(posedge clock);
    finish_test();
  end
endmodule

// >>> verilog/tc_pkg.sv
// Purpose: constants and state layout of the ttl panel timing controller
// Assumes: avalon-mm byte addresses, one 32-bit word per register
// Notes:   positions are 12-bit, strobe index order is fixed below
package tc_pkg;
  // register byte offsets
  localparam logic [7:0] TC_CTRL_OFS  = 8'h00;
  localparam logic [7:0] TC_TYPE_OFS  = 8'h04;
  localparam logic [7:0] TC_HTOT_OFS  = 8'h08;
  localparam logic [7:0] TC_VTOT_OFS  = 8'h0c;
  localparam logic [7:0] TC_HACT_OFS  = 8'h10;
  localparam logic [7:0] TC_VACT_OFS  = 8'h14;
  localparam logic [7:0] TC_PLL_OFS   = 8'h18;
  localparam logic [7:0] TC_DIV_OFS   = 8'h1c;
  localparam logic [7:0] TC_CLK_OFS   = 8'h20;
  localparam logic [7:0] TC_STAT_OFS  = 8'h24;
  localparam logic [7:0] TC_POS_OFS   = 8'h40;
  // strobes and position slots
  localparam int TC_NSTB   = 6;
  localparam int TC_NPOS   = 24;
  localparam int TC_STB_SS = 0;  // source start
  localparam int TC_STB_SO = 1;  // source output enable
  localparam int TC_STB_CT = 2;  // com toggle
  localparam int TC_STB_GC = 3;  // gate shift clock
  localparam int TC_STB_GS = 4;  // gate start
  localparam int TC_STB_GO = 5;  // gate output enable
  localparam int TC_SL_HS  = 0;
  localparam int TC_SL_HE  = 1;
  localparam int TC_SL_VS  = 2;
  localparam int TC_SL_VE  = 3;
  // control register fields
  localparam int TC_EN_BIT     = 0;
  localparam int TC_POL_LSB    = 1;
  localparam int TC_PINSEL_LSB = 12;
  localparam int TC_PIN_CKC    = 12;
  localparam int TC_PIN_CKB    = 13;
  localparam int TC_PIN_CKA    = 14;
  localparam int TC_PIN_OF [TC_NSTB] = '{19, 17, 20, 16, 18, 15};
  // clock field positions
  localparam int TC_DIV_LSB = 4;
  localparam int TC_SS_LSB  = 16;
  localparam logic [3:0] TC_SS_MAX = 4'h5;
  // fixed start of internal image data
  localparam logic [11:0] TC_VON_PIX  = 12'h030;
  localparam logic [11:0] TC_VON_LINE = 12'h016;
  // reset values
  localparam logic [11:0] TC_HTOT_RST = 12'h420;
  localparam logic [11:0] TC_VTOT_RST = 12'h20d;
  localparam logic [11:0] TC_HACT_RST = 12'h320;
  localparam logic [11:0] TC_VACT_RST = 12'h1e0;
  localparam logic [5:0]  TC_TYPE_RST = 6'h10;
  localparam logic [3:0]  TC_XD_RST   = 4'h1;
  // whole state of the controller
  typedef struct packed {
    logic                     wreq;
    logic [31:0]              rdata;
    logic                     en;
    logic [2:0]               pol;
    logic [8:0]               pinsel;
    logic [5:0]               ftype;
    logic [11:0]              htot;
    logic [11:0]              vtot;
    logic [11:0]              hact;
    logic [11:0]              vact;
    logic [17:0]              pll;
    logic [3:0]               divc;
    logic [3:0]               xd;
    logic [3:0]               ss;
    logic [TC_NPOS-1:0][11:0] pos;
    logic [7:0]               divcnt;
    logic [11:0]              hcnt;
    logic [11:0]              vcnt;
    logic                     com;
    logic [5:0]               stb;
    logic [2:0]               pclk;
    logic [23:0]              rgb;
    logic                     de;
  } tc_st_s;
endpackage

// >>> verilog/tc_timing_ctrl.sv
// Purpose: ttl panel timing controller with avalon-mm register slave
// Assumes: pixel_in comes from logic on the same clock
// Notes:   pixel rate is an enable pulse derived from the system clock
// How it works
// - rgb out on 24 bits, 8 per colour
// - nine pin-select enables, bits 12 to 20
// - frame strobe holds across line boundaries
// - line strobe drops at each line end, except a window over the whole line
// - six strobes each selectable line or frame
// - strobes timed on the pixel clock enable
// - four position registers per strobe
// - positions hold 12 bits, 0 to 4095
// - active from hstart through hend inclusive
// - pixel counter starts at zero
// - window applies from vstart through vend
// - line counter starts at zero
// - image start position fixed in hardware
// - divider settings take effect while running
// - spread level 0 to 5 at bits 19:16
// - totals set line and frame length
module tc_timing_ctrl
  import tc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [23:0] pixel_in,
  output logic      [23:0] rgb_out,
  output logic             data_enable,
  output logic             source_start_strobe,
  output logic             source_output_enable,
  output logic             com_toggle_strobe,
  output logic             gate_shift_clock,
  output logic             gate_start_strobe,
  output logic             gate_output_enable,
  output logic             pixel_clock_out_a,
  output logic             pixel_clock_out_b,
  output logic             pixel_clock_out_c
);

  // register map, byte offsets, one word each:
  //   0x00 control: enable, clock polarity,
  //        pin-select enables
  //   0x04 strobe type, one bit a strobe, 1 = frame
  //   0x08 line total, 0x0c frame total
  //   0x10 image width, 0x14 image height
  //   0x18 clock multiplier and pre-dividers
  //   0x1c divider in bits 7:4
  //   0x20 final divider, spread level at 19:16
  //   0x24 live position, read only
  //   0x40 on: four position words per strobe
  // misaligned or unmapped reads give zero
  // writes there are dropped without error
  // the slot after the com switch point is unused
  //
  // bus timing: waitrequest idles high, so each
  // access sees exactly one wait cycle
  // read data are loaded at the first edge and
  // stand at the edge where waitrequest is low
  // writes land at that same accepting edge
  // back-to-back accesses cost two cycles each
  //
  // pixel timing: one pixel step every period
  // system clocks, period = (div + 1) * xd
  // a final divider of zero counts as one
  // the step compare uses >=, so a period cut
  // while running never strands the count
  // strobes, rgb and data enable move at the same
  // edge as the step and show the old position
  //
  // limits: no clock synthesis here; multiplier,
  // pre-dividers and spread level are only kept
  // for the clock block outside
  logic [1:0]        rsync_ff;  // reset release synchroniser
  logic              rst_n;     // synchronised reset
  tc_st_s            st_ff;     // registered state
  tc_st_s            nxt_st;    // next state
  logic [TC_NSTB-1:0] hit;      // per-strobe window or toggle hit

  // byteenable keeps the bytes not written, so
  // software can update one field of a word
  // merge written bytes into an old word
  function automatic logic [31:0] tc_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // nrst may drop at any time; its release is
  // retimed so all state leaves reset on one edge
  // reset released through two flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rsync_ff <= 2'b00;
    end else begin
      rsync_ff <= {rsync_ff[0], 1'b1};
    end
  end
  assign rst_n = rsync_ff[1];

  // each strobe owns four position slots, hstart,
  // hend, vstart and vend, at slot s*4
  // line type: the hstart..hend window repeats on
  // every line from vstart to vend, so the output
  // drops between lines except for a full line
  // frame type: one run from (vstart, hstart) to
  // (vend, hend) that stays up across line ends
  // on a line-type strobe, an hend below hstart gives an empty window
  // com has no end slot: it flips at hswitch
  // per-strobe window compare
  genvar g;
  generate
    for (g = 0; g < TC_NSTB; g++) begin : g_stb
      logic [11:0] hs;  // first active pixel
      logic [11:0] he;  // last active pixel
      logic [11:0] vs;  // first active line
      logic [11:0] ve;  // last active line
      logic        lwin; // line-type window
      logic        fwin; // frame-type window
      assign hs = st_ff.pos[g*4+TC_SL_HS];
      assign he = st_ff.pos[g*4+TC_SL_HE];
      assign vs = st_ff.pos[g*4+TC_SL_VS];
      assign ve = st_ff.pos[g*4+TC_SL_VE];
      // inside hs..he on each line of vs..ve
      assign lwin = (st_ff.vcnt >= vs) && (st_ff.vcnt <= ve)
                 && (st_ff.hcnt >= hs) && (st_ff.hcnt <= he);
      // from (vs,hs) to (ve,he) without line gaps
      assign fwin = ((st_ff.vcnt > vs) ||
                     ((st_ff.vcnt == vs) && (st_ff.hcnt >= hs)))
                 && ((st_ff.vcnt < ve) ||
                     ((st_ff.vcnt == ve) && (st_ff.hcnt <= he)));
      if (g == TC_STB_CT) begin : g_com
        // com toggles at hswitch: each line or once a frame
        assign hit[g] = (st_ff.hcnt == hs) &&
          (st_ff.ftype[g] ? (st_ff.vcnt == vs)
                          : ((st_ff.vcnt >= vs) && (st_ff.vcnt <= ve)));
      end else begin : g_win
        assign hit[g] = st_ff.ftype[g] ? fwin : lwin;
      end
    end
  endgenerate

  // the controller is one state struct; this
  // process works out its next value each clock
  // order: bus decode and read mux, waitrequest
  // and write, pixel divider, counters, strobes
  // and image region
  // next state: bus slave, pixel divider, counters, strobes
  always_comb begin
    logic        req;     // bus request present
    logic [5:0]  widx;    // word index of position slot
    logic [31:0] cur;     // current word at address
    logic [31:0] mw;      // merged write word
    logic [7:0]  period;  // system clocks per pixel
    logic [7:0]  half;    // high time of pixel clock out
    logic [3:0]  xde;     // final divider, zero read as one
    logic        pix_en;  // one pixel step
    logic        in_act;  // inside image region
    logic [11:0] hx;      // pixel offset into image
    logic [11:0] vx;      // line offset into image
    req    = 1'b0;
    widx   = 6'h00;
    cur    = 32'h0000_0000;
    mw     = 32'h0000_0000;
    period = 8'h01;
    half   = 8'h00;
    xde    = 4'h1;
    pix_en = 1'b0;
    in_act = 1'b0;
    hx     = 12'h000;
    vx     = 12'h000;
    nxt_st = st_ff;
    req    = avs_read | avs_write;
    widx   = 6'((avs_address - TC_POS_OFS) >> 2);
    // read mux, unmapped reads zero
    case (avs_address)
      TC_CTRL_OFS: begin
        cur = {11'h000, st_ff.pinsel, 8'h00, st_ff.pol, st_ff.en};
      end
      TC_TYPE_OFS: cur = {26'h000_0000, st_ff.ftype};
      TC_HTOT_OFS: cur = {20'h0_0000, st_ff.htot};
      TC_VTOT_OFS: cur = {20'h0_0000, st_ff.vtot};
      TC_HACT_OFS: cur = {20'h0_0000, st_ff.hact};
      TC_VACT_OFS: cur = {20'h0_0000, st_ff.vact};
      TC_PLL_OFS:  cur = {14'h0000, st_ff.pll};
      TC_DIV_OFS:  cur = {24'h00_0000, st_ff.divc, 4'h0};
      TC_CLK_OFS:  cur = {12'h000, st_ff.ss, 12'h000, st_ff.xd};
      TC_STAT_OFS: cur = {4'h0, st_ff.vcnt, 4'h0, st_ff.hcnt};
      default: begin
        // position slots, unused com slot reads zero
        if (avs_address >= TC_POS_OFS && avs_address[1:0] == 2'b00 &&
            widx < 6'(TC_NPOS) &&
            widx != 6'(TC_STB_CT*4+TC_SL_HE)) begin
          cur = {20'h0_0000, st_ff.pos[widx]};
        end
      end
    endcase
    mw = tc_merge(cur, avs_writedata, avs_byteenable);
    // a read loads its data at the first edge, so
    // the value stands when the master takes it
    // waitrequest drops one cycle after a request
    if (req && st_ff.wreq) begin
      nxt_st.wreq  = 1'b0;
      nxt_st.rdata = avs_read ? cur : st_ff.rdata;
    end else if (req) begin
      nxt_st.wreq = 1'b1;
      // write takes effect at the accepting edge
      if (avs_write) begin
        case (avs_address)
          TC_CTRL_OFS: begin
            nxt_st.en     = mw[TC_EN_BIT];
            nxt_st.pol    = mw[TC_POL_LSB +: 3];
            nxt_st.pinsel = mw[TC_PINSEL_LSB +: 9];
          end
          TC_TYPE_OFS: nxt_st.ftype = mw[5:0];
          TC_HTOT_OFS: nxt_st.htot  = mw[11:0];
          TC_VTOT_OFS: nxt_st.vtot  = mw[11:0];
          TC_HACT_OFS: nxt_st.hact  = mw[11:0];
          TC_VACT_OFS: nxt_st.vact  = mw[11:0];
          TC_PLL_OFS:  nxt_st.pll   = mw[17:0];
          TC_DIV_OFS:  nxt_st.divc  = mw[TC_DIV_LSB +: 4];
          TC_CLK_OFS: begin
            nxt_st.xd = mw[3:0];
            // level above five is held at five
            nxt_st.ss = (mw[TC_SS_LSB +: 4] > TC_SS_MAX) ?
                        TC_SS_MAX : mw[TC_SS_LSB +: 4];
          end
          default: begin
            if (avs_address >= TC_POS_OFS &&
                avs_address[1:0] == 2'b00 &&
                widx < 6'(TC_NPOS) &&
                widx != 6'(TC_STB_CT*4+TC_SL_HE)) begin
              nxt_st.pos[widx] = mw[11:0];
            end
          end
        endcase
      end
    end else begin
      nxt_st.wreq = 1'b1;
    end
    // divider settings are read live, so a write
    // changes the pixel rate from the next step
    // on, without stopping the display
    // pixel period from live divider settings
    xde    = (st_ff.xd == 4'h0) ? 4'h1 : st_ff.xd;
    period = 8'(({4'h0, st_ff.divc} + 8'h01) * {4'h0, xde});
    half   = period >> 1;
    pix_en = st_ff.en && (st_ff.divcnt >= period - 8'h01);
    if (!st_ff.en) begin
      // enable low parks everything, so the next
      // enable starts a clean frame at (0, 0)
      // idle: counters parked, outputs low
      nxt_st.divcnt = 8'h00;
      nxt_st.hcnt   = 12'h000;
      nxt_st.vcnt   = 12'h000;
      nxt_st.com    = 1'b0;
      nxt_st.stb    = 6'h00;
      nxt_st.pclk   = 3'b000;
      nxt_st.rgb    = 24'h00_0000;
      nxt_st.de     = 1'b0;
    end else begin
      nxt_st.divcnt = pix_en ? 8'h00 : st_ff.divcnt + 8'h01;
      // clock outs are high for the first half
      // period of each pixel, low for the rest;
      // a period of one leaves them constant
      // polarity is applied first, then the pin
      // gate, so an unselected pad is low either way
      // pixel clock outs, polarity per output
      nxt_st.pclk = {3{nxt_st.divcnt < half}} ^ st_ff.pol;
      nxt_st.pclk[0] = nxt_st.pclk[0] &
                       st_ff.pinsel[TC_PIN_CKA-TC_PINSEL_LSB];
      nxt_st.pclk[1] = nxt_st.pclk[1] &
                       st_ff.pinsel[TC_PIN_CKB-TC_PINSEL_LSB];
      nxt_st.pclk[2] = nxt_st.pclk[2] &
                       st_ff.pinsel[TC_PIN_CKC-TC_PINSEL_LSB];
      if (pix_en) begin
        // h runs 0..htot-1, then v steps; v wraps
        // after vtot-1; >= catches totals lowered
        // below the current count while running
        // pixel and line counters from zero
        if (st_ff.hcnt >= st_ff.htot - 12'h001) begin
          nxt_st.hcnt = 12'h000;
          if (st_ff.vcnt >= st_ff.vtot - 12'h001) begin
            nxt_st.vcnt = 12'h000;
          end else begin
            nxt_st.vcnt = st_ff.vcnt + 12'h001;
          end
        end else begin
          nxt_st.hcnt = st_ff.hcnt + 12'h001;
        end
        // each strobe is gated by its pin-select
        // bit, so an unselected pad stays low
        // strobes sampled from current position
        for (int s = 0; s < TC_NSTB; s++) begin
          if (s == TC_STB_CT) begin
            nxt_st.com = st_ff.com ^ hit[s];
            nxt_st.stb[s] = nxt_st.com &
                            st_ff.pinsel[TC_PIN_OF[s]-TC_PINSEL_LSB];
          end else begin
            nxt_st.stb[s] = hit[s] &
                            st_ff.pinsel[TC_PIN_OF[s]-TC_PINSEL_LSB];
          end
        end
        // image data start at a fixed pixel and
        // line; outside the image rgb is held at zero
        // image region from fixed start position
        hx = st_ff.hcnt - TC_VON_PIX;
        vx = st_ff.vcnt - TC_VON_LINE;
        in_act = (st_ff.hcnt >= TC_VON_PIX) && (hx < st_ff.hact) &&
                 (st_ff.vcnt >= TC_VON_LINE) && (vx < st_ff.vact);
        nxt_st.de  = in_act;
        nxt_st.rgb = in_act ? pixel_in : 24'h00_0000;
      end
    end
  end

  // reset values: totals and image size of the
  // default panel, gate start as frame type,
  // final divider one, waitrequest high; the rest clears to zero
  // single state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff       <= '0;
      st_ff.wreq  <= 1'b1;
      st_ff.htot  <= TC_HTOT_RST;
      st_ff.vtot  <= TC_VTOT_RST;
      st_ff.hact  <= TC_HACT_RST;
      st_ff.vact  <= TC_VACT_RST;
      st_ff.ftype <= TC_TYPE_RST;
      st_ff.xd    <= TC_XD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every output is a plain copy of a state
  // flop, so no pad sees a combinational glitch
  // outputs straight from state flops
  assign avs_readdata         = st_ff.rdata;
  assign avs_waitrequest      = st_ff.wreq;
  assign rgb_out              = st_ff.rgb;
  assign data_enable          = st_ff.de;
  assign source_start_strobe  = st_ff.stb[TC_STB_SS];
  assign source_output_enable = st_ff.stb[TC_STB_SO];
  assign com_toggle_strobe    = st_ff.stb[TC_STB_CT];
  assign gate_shift_clock     = st_ff.stb[TC_STB_GC];
  assign gate_start_strobe    = st_ff.stb[TC_STB_GS];
  assign gate_output_enable   = st_ff.stb[TC_STB_GO];
  assign pixel_clock_out_a    = st_ff.pclk[0];
  assign pixel_clock_out_b    = st_ff.pclk[1];
  assign pixel_clock_out_c    = st_ff.pclk[2];

endmodule
